// File: logic/data_nvm_access_controller.sv
// Data nonvolatile memory controller: control registers, external-move
// routing, timed page erase and byte program, done flag and interrupt.
// Assumes one core clock, synchronous reset, and a core port on the link.
//
// Notes on behaviour
// - Array access only while access enable set.
// - Software erases page before programming bytes.
// - Erase request with enable starts page erase.
// - Completion sets done flag until software clears.
// - Done flag raises interrupt when enabled.
// - Erase request bit clears after erase ends.
// - Page erase lasts about five milliseconds.
// - Write request with enable programs one byte.
// - Byte program lasts about fifty microseconds.
// - Pointer reads: array in range, else external.
// - Indirect reads use high byte register; else nothing.
// - Moves never program; pointer writes out go external.
// - Out-of-range erase or program is ignored.
// - Page decoded from address registers.
// - Erase and program exclude each other.
// - No new operation while done flag set.
// - Address writes ignored during any operation.
// - Data writes ignored only during program.
`timescale 1ns/1ps
`include "nvm_params.svh"
module data_nvm_access_controller #(
  parameter bit                      LARGE        = 1'b1,
  parameter logic [`NVM_TIMER_W-1:0] ERASE_CYCLES = `NVM_TIMER_W'(`NVM_ERASE_CYCLES),
  parameter logic [`NVM_TIMER_W-1:0] PROG_CYCLES  = `NVM_TIMER_W'(`NVM_PROG_CYCLES)
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Link from the core
  nvm_if.dev        bus,
  // Status to the core
  output logic      irq,
  output logic      op_busy
);
  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic in_array(input logic [15:0] a);
    in_array = LARGE ? (a < `NVM_SIZE_LARGE) : (a < `NVM_SIZE_SMALL);
  endfunction

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  logic                 erase_req_q;
  logic                 write_req_q;
  logic                 enable_q;
  logic                 done_q;
  logic                 irq_en_q;
  logic [7:0]           addr_hi_q;
  logic [7:0]           addr_lo_q;
  logic [7:0]           wdata_q;
  logic [7:0]           xram_hi_q;
  logic                 ack_q;
  logic [7:0]           rdata_q;
  nvm_pkg::route_e      route_q;
  logic [15:0]          rsp_addr_q;
  nvm_pkg::op_state_e   state_q;
  nvm_pkg::op_state_e   state_d;
  logic [7:0]           mem_q [0:`NVM_DEPTH-1];

  // --------------------------------------------------------------------
  // Request decode
  // --------------------------------------------------------------------
  logic                    take;
  logic                    sfr_wr;
  logic                    wr_ctrl;
  logic                    wr_addr_hi;
  logic                    wr_addr_lo;
  logic                    wr_wdata;
  logic                    wr_xram_hi;
  logic                    wr_irq_en;
  logic                    idle;
  logic [15:0]             op_addr;
  logic [4:0]              op_page;
  logic                    op_ok;
  logic                    start_erase;
  logic                    start_prog;
  logic [`NVM_TIMER_W-1:0] op_cycles;
  logic                    t_done;
  logic                    erase_end;
  logic                    prog_end;

  assign take       = bus.req && !ack_q;
  assign sfr_wr     = take && (bus.kind == nvm_pkg::KIND_SFR_WR);
  assign wr_ctrl    = sfr_wr && (bus.sel == `NVM_SFR_CONTROL);
  assign wr_addr_hi = sfr_wr && (bus.sel == `NVM_SFR_ADDR_HIGH) && idle;
  assign wr_addr_lo = sfr_wr && (bus.sel == `NVM_SFR_ADDR_LOW) && idle;
  assign wr_wdata   = sfr_wr && (bus.sel == `NVM_SFR_WRITE_DATA)
                      && (state_q != nvm_pkg::ST_PROG);
  assign wr_xram_hi = sfr_wr && (bus.sel == `NVM_SFR_XRAM_HIGH);
  assign wr_irq_en  = sfr_wr && (bus.sel == `NVM_SFR_IRQ_ENABLE);
  assign idle       = (state_q == nvm_pkg::ST_IDLE);

  assign op_addr = {addr_hi_q, addr_lo_q};
  assign op_page = op_addr[`NVM_PAGE_MSB:`NVM_PAGE_LSB];
  // Idle covers mutual exclusion; done blocks a restart
  assign op_ok   = in_array(op_addr) && idle && !done_q
                   && bus.wdata[`NVM_CTRL_ENABLE_BIT];
  assign start_erase = wr_ctrl && op_ok && bus.wdata[`NVM_CTRL_ERASE_BIT];
  assign start_prog  = wr_ctrl && op_ok && bus.wdata[`NVM_CTRL_WRITE_BIT]
                       && !bus.wdata[`NVM_CTRL_ERASE_BIT];
  assign op_cycles   = start_erase ? ERASE_CYCLES : PROG_CYCLES;
  assign erase_end   = t_done && (state_q == nvm_pkg::ST_ERASE);
  assign prog_end    = t_done && (state_q == nvm_pkg::ST_PROG);

  nvm_op_timer u_nvm_op_timer (
    .clk    (clk),
    .rst_n  (rst_n),
    .start  (start_erase || start_prog),
    .cycles (op_cycles),
    .busy   (),
    .done   (t_done)
  );

  // --------------------------------------------------------------------
  // Operation sequencer
  // --------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      nvm_pkg::ST_IDLE: begin
        if (start_erase) begin
          state_d = nvm_pkg::ST_ERASE;
        end else if (start_prog) begin
          state_d = nvm_pkg::ST_PROG;
        end
      end
      nvm_pkg::ST_ERASE: begin
        if (t_done) begin
          state_d = nvm_pkg::ST_IDLE;
        end
      end
      nvm_pkg::ST_PROG: begin
        if (t_done) begin
          state_d = nvm_pkg::ST_IDLE;
        end
      end
      default: state_d = nvm_pkg::ST_IDLE;
    endcase
  end

  // --------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q     <= nvm_pkg::ST_IDLE;
      erase_req_q <= 1'b0;
      write_req_q <= 1'b0;
      enable_q    <= 1'b0;
      done_q      <= 1'b0;
      irq_en_q    <= 1'b0;
      addr_hi_q   <= `NVM_SFR_RESET;
      addr_lo_q   <= `NVM_SFR_RESET;
      wdata_q     <= `NVM_SFR_RESET;
      xram_hi_q   <= `NVM_SFR_RESET;
      irq         <= 1'b0;
      op_busy     <= 1'b0;
    end else begin
      state_q <= state_d;
      op_busy <= (state_d != nvm_pkg::ST_IDLE);
      if (wr_ctrl) begin
        enable_q <= bus.wdata[`NVM_CTRL_ENABLE_BIT];
      end
      if (start_erase) begin
        erase_req_q <= 1'b1;
      end else if (erase_end) begin
        erase_req_q <= 1'b0;
      end
      if (start_prog) begin
        write_req_q <= 1'b1;
      end else if (prog_end) begin
        write_req_q <= 1'b0;
      end
      // Completion wins over a same-cycle software clear
      if (t_done) begin
        done_q <= 1'b1;
      end else if (wr_ctrl && !bus.wdata[`NVM_CTRL_DONE_BIT]) begin
        done_q <= 1'b0;
      end
      if (wr_addr_hi) begin
        addr_hi_q <= bus.wdata;
      end
      if (wr_addr_lo) begin
        addr_lo_q <= bus.wdata;
      end
      if (wr_wdata) begin
        wdata_q <= bus.wdata;
      end
      if (wr_xram_hi) begin
        xram_hi_q <= bus.wdata;
      end
      if (wr_irq_en) begin
        irq_en_q <= bus.wdata[`NVM_IRQ_EN_BIT];
      end
      irq <= done_q && irq_en_q;
    end
  end

  // --------------------------------------------------------------------
  // Array: erase fills a page, program can only clear bits
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (erase_end) begin
      for (int i = 0; i < `NVM_PAGE_BYTES; i++) begin
        mem_q[{op_page, i[5:0]}] <= `NVM_ERASED_BYTE;
      end
    end else if (prog_end) begin
      mem_q[op_addr[10:0]] <= mem_q[op_addr[10:0]] & wdata_q;
    end
  end

  // --------------------------------------------------------------------
  // External move routing
  // --------------------------------------------------------------------
  logic [15:0]     mv_addr;
  logic            mv_in;
  logic            mv_rd;
  logic            mv_wr;
  nvm_pkg::route_e mv_route;
  logic [7:0]      sfr_rd;
  logic [7:0]      ctrl_rd;

  assign mv_addr = bus.indirect ? {xram_hi_q, bus.addr[7:0]} : bus.addr;
  assign mv_in   = in_array(mv_addr);
  assign mv_rd   = (bus.kind == nvm_pkg::KIND_MOVE_RD);
  assign mv_wr   = (bus.kind == nvm_pkg::KIND_MOVE_WR);
  assign mv_route =
      !enable_q              ? nvm_pkg::ROUTE_EXT   :
      (mv_rd && mv_in)       ? nvm_pkg::ROUTE_ARRAY :
      (mv_rd && bus.indirect) ? nvm_pkg::ROUTE_NONE :
      mv_rd                  ? nvm_pkg::ROUTE_EXT   :
      (mv_in || bus.indirect) ? nvm_pkg::ROUTE_NONE :
                               nvm_pkg::ROUTE_EXT;

  assign ctrl_rd = {erase_req_q, write_req_q, enable_q, done_q, 4'h0};
  assign sfr_rd =
      (bus.sel == `NVM_SFR_CONTROL)    ? ctrl_rd   :
      (bus.sel == `NVM_SFR_ADDR_HIGH)  ? addr_hi_q :
      (bus.sel == `NVM_SFR_ADDR_LOW)   ? addr_lo_q :
      (bus.sel == `NVM_SFR_WRITE_DATA) ? wdata_q   :
      (bus.sel == `NVM_SFR_XRAM_HIGH)  ? xram_hi_q :
      (bus.sel == `NVM_SFR_IRQ_ENABLE) ? {2'h0, irq_en_q, 5'h00} : 8'h00;

  // --------------------------------------------------------------------
  // Answer to the core
  // --------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_q      <= 1'b0;
      rdata_q    <= 8'h00;
      route_q    <= nvm_pkg::ROUTE_NONE;
      rsp_addr_q <= 16'h0000;
    end else begin
      ack_q <= take;
      if (take) begin
        rsp_addr_q <= mv_addr;
        route_q    <= (mv_rd || mv_wr) ? mv_route : nvm_pkg::ROUTE_NONE;
        if (bus.kind == nvm_pkg::KIND_SFR_RD) begin
          rdata_q <= sfr_rd;
        end else if (mv_rd && (mv_route == nvm_pkg::ROUTE_ARRAY)) begin
          rdata_q <= mem_q[mv_addr[10:0]];
        end else begin
          rdata_q <= 8'h00;
        end
      end
    end
  end

  assign bus.ack      = ack_q;
  assign bus.rdata    = rdata_q;
  assign bus.route    = route_q;
  assign bus.rsp_addr = rsp_addr_q;
endmodule

// File: logic/nvm_params.svh
// Constants of the data nonvolatile memory controller: register codes,
// field positions, reset values and operation timing.
// Assumes a 200 MHz core clock; included by bare name.
`ifndef NVM_PARAMS_SVH
`define NVM_PARAMS_SVH

// ----------------------------------------------------------------------
// Clock and operation timing
// ----------------------------------------------------------------------
`define NVM_CLK_MHZ          200
`define NVM_ERASE_TIME_US    5000
`define NVM_PROG_TIME_NS     50000
`define NVM_ERASE_CYCLES     (`NVM_ERASE_TIME_US * `NVM_CLK_MHZ)
`define NVM_PROG_CYCLES      ((`NVM_PROG_TIME_NS * `NVM_CLK_MHZ) / 1000)
`define NVM_TIMER_W          20

// ----------------------------------------------------------------------
// Register select codes
// ----------------------------------------------------------------------
`define NVM_SFR_CONTROL      3'h0
`define NVM_SFR_ADDR_HIGH    3'h1
`define NVM_SFR_ADDR_LOW     3'h2
`define NVM_SFR_WRITE_DATA   3'h3
`define NVM_SFR_XRAM_HIGH    3'h4
`define NVM_SFR_IRQ_ENABLE   3'h5

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define NVM_CTRL_ERASE_BIT   7
`define NVM_CTRL_WRITE_BIT   6
`define NVM_CTRL_ENABLE_BIT  5
`define NVM_CTRL_DONE_BIT    4
`define NVM_IRQ_EN_BIT       5
`define NVM_SFR_RESET        8'h00

// ----------------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------------
`define NVM_SIZE_SMALL       16'h0400
`define NVM_SIZE_LARGE       16'h0800
`define NVM_DEPTH            2048
`define NVM_PAGE_BYTES       64
`define NVM_PAGE_MSB         10
`define NVM_PAGE_LSB         6
`define NVM_ERASED_BYTE      8'hFF

`endif

// File: logic/nvm_pkg.sv
// Types shared by both ends of the nonvolatile memory link.
// Assumes nothing beyond a SystemVerilog compiler.
package nvm_pkg;

  typedef enum logic [1:0] {
    KIND_SFR_WR  = 2'h0,
    KIND_SFR_RD  = 2'h1,
    KIND_MOVE_RD = 2'h2,
    KIND_MOVE_WR = 2'h3
  } req_kind_e;

  typedef enum logic [1:0] {
    ROUTE_NONE  = 2'h0,
    ROUTE_ARRAY = 2'h1,
    ROUTE_EXT   = 2'h2
  } route_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_ERASE = 2'h1,
    ST_PROG  = 2'h2
  } op_state_e;

endpackage

// File: logic/nvm_if.sv
// Link between the CPU core port and the nonvolatile memory controller.
// Assumes both ends share one clock; request held until acknowledged.
`timescale 1ns/1ps
interface nvm_if;
  logic               req;
  nvm_pkg::req_kind_e kind;
  logic [2:0]         sel;
  logic [15:0]        addr;
  logic [7:0]         wdata;
  logic               indirect;
  logic               ack;
  logic [7:0]         rdata;
  nvm_pkg::route_e    route;
  logic [15:0]        rsp_addr;

  modport dev (input req, kind, sel, addr, wdata, indirect,
               output ack, rdata, route, rsp_addr);
  modport core (output req, kind, sel, addr, wdata, indirect,
                input ack, rdata, route, rsp_addr);
endinterface

// File: logic/nvm_op_timer.sv
// Down counter timing one erase or program operation.
// Assumes start is a single-cycle pulse given only while idle.
`timescale 1ns/1ps
`include "nvm_params.svh"
module nvm_op_timer (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Control
  input  wire logic                    start,
  input  wire logic [`NVM_TIMER_W-1:0] cycles,
  // Status
  output logic                         busy,
  output logic                         done
);
  logic [`NVM_TIMER_W-1:0] count_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_q <= '0;
      busy    <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count_q <= cycles - `NVM_TIMER_W'(1);
        busy    <= 1'b1;
      end else if (busy) begin
        if (count_q == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count_q <= count_q - `NVM_TIMER_W'(1);
        end
      end
    end
  end
endmodule

// File: logic/nvm_core_port.sv
// CPU core end: turns register and external-move commands into link requests.
// Assumes the user side holds cmd_valid until cmd_ready is seen high.
`timescale 1ns/1ps
`include "nvm_params.svh"
module nvm_core_port (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_n,
  // Command from the core
  input  wire logic                cmd_valid,
  input  nvm_pkg::req_kind_e       cmd_kind,
  input  wire logic [2:0]          cmd_sel,
  input  wire logic [15:0]         cmd_addr,
  input  wire logic [7:0]          cmd_data,
  input  wire logic                cmd_indirect,
  output logic                     cmd_ready,
  // Answer to the core
  output logic                     rsp_valid,
  output logic [7:0]               rsp_data,
  output nvm_pkg::route_e          rsp_route,
  output logic [15:0]              rsp_addr,
  // Link to the controller
  nvm_if.core                      bus
);
  logic take;

  // register writes pass in issue order
  assign take = cmd_valid && cmd_ready;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cmd_ready    <= 1'b1;
      rsp_valid    <= 1'b0;
      rsp_data     <= 8'h00;
      rsp_route    <= nvm_pkg::ROUTE_NONE;
      rsp_addr     <= 16'h0000;
      bus.req      <= 1'b0;
      bus.kind     <= nvm_pkg::KIND_SFR_RD;
      bus.sel      <= 3'h0;
      bus.addr     <= 16'h0000;
      bus.wdata    <= 8'h00;
      bus.indirect <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      if (take) begin
        cmd_ready    <= 1'b0;
        bus.req      <= 1'b1;
        bus.kind     <= cmd_kind;
        bus.sel      <= cmd_sel;
        bus.addr     <= cmd_addr;
        bus.wdata    <= cmd_data;
        bus.indirect <= cmd_indirect;
      end else if (bus.req && bus.ack) begin
        bus.req   <= 1'b0;
        cmd_ready <= 1'b1;
        rsp_valid <= 1'b1;
        rsp_data  <= bus.rdata;
        rsp_route <= bus.route;
        rsp_addr  <= bus.rsp_addr;
      end
    end
  end
endmodule

// File: test/nvm_link_properties.sv
// Concurrent checks on the link between core port and controller.
// Assumes the 2K array and the link signals handed in as plain inputs.
`timescale 1ns/1ps
module nvm_link_properties (
  // Clock and reset
  input wire logic          clk,
  input wire logic          rst_n,
  // Link
  input wire logic          req,
  input nvm_pkg::req_kind_e kind,
  input wire logic [15:0]   addr,
  input wire logic          indirect,
  input wire logic          ack,
  input wire logic [7:0]    rdata,
  input nvm_pkg::route_e    route,
  input wire logic [15:0]   rsp_addr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  wire mv_rd = ack && kind == nvm_pkg::KIND_MOVE_RD;
  wire mv_wr = ack && kind == nvm_pkg::KIND_MOVE_WR;

  // ------------------------------
  // Handshake
  // ------------------------------
  sequence take_s;
    req && !ack;
  endsequence
  sequence pulse_s;
    ack ##1 !ack;
  endsequence

  take_answer_a: assert property (take_s |=> pulse_s)
    else $error("request not answered by one ack pulse");
  idle_quiet_a: assert property (!req |=> !ack)
    else $error("ack without request");

  // ------------------------------
  // Move routing
  // ------------------------------
  wr_no_array_a: assert property (mv_wr |-> route != nvm_pkg::ROUTE_ARRAY)
    else $error("move write routed to array");
  ind_wr_none_a: assert property (mv_wr && indirect |-> route == nvm_pkg::ROUTE_NONE)
    else $error("indirect write not a no-operation");
  ptr_wr_ext_a: assert property (mv_wr && !indirect && addr >= 16'h0800
    |-> route == nvm_pkg::ROUTE_EXT) else $error("far pointer write not external");
  ptr_rd_ext_a: assert property (mv_rd && !indirect && addr >= 16'h0800
    |-> route == nvm_pkg::ROUTE_EXT) else $error("far pointer read not external");
  ind_low_byte_a: assert property (mv_rd && indirect |-> rsp_addr[7:0] == addr[7:0])
    else $error("indirect low byte wrong");
  array_bound_a: assert property (ack && route == nvm_pkg::ROUTE_ARRAY
    |-> rsp_addr < 16'h0800) else $error("array hit beyond boundary");
  other_zero_a: assert property (mv_rd && route != nvm_pkg::ROUTE_ARRAY
    |-> rdata == 8'h00) else $error("non-array read carries data");
endmodule

// File: test/test_data_nvm_access_controller.sv
// Self-checking bench: core port and controller joined by the link.
// Assumes shortened operation times set through the controller parameters.
`timescale 1ns/1ps
module test_data_nvm_access_controller;
  localparam int         ERASE = 80;
  localparam int         PROG  = 30;
  localparam logic [15:0] R_NONE = 16'(nvm_pkg::ROUTE_NONE);
  localparam logic [15:0] R_ARR  = 16'(nvm_pkg::ROUTE_ARRAY);
  localparam logic [15:0] R_EXT  = 16'(nvm_pkg::ROUTE_EXT);

  logic               clk = 1'b0;
  logic               rst_n = 1'b0;
  logic               cmd_valid = 1'b0;
  nvm_pkg::req_kind_e cmd_kind = nvm_pkg::KIND_SFR_RD;
  logic [2:0]         cmd_sel = 3'h0;
  logic [15:0]        cmd_addr = 16'h0000;
  logic [7:0]         cmd_data = 8'h00;
  logic               cmd_indirect = 1'b0;
  logic               cmd_ready;
  logic               rsp_valid;
  logic [7:0]         rsp_data;
  nvm_pkg::route_e    rsp_route;
  logic [15:0]        rsp_addr;
  logic               irq;
  logic               op_busy;
  logic [15:0]        got_d;
  logic [15:0]        got_r;
  logic [15:0]        got_a;
  int                 bad_count = 0;
  int                 comparisons = 0;
  int                 busy_cnt = 0;
  int                 busy_base = 0;

  always #2.5 clk = ~clk;
  always @(posedge clk) if (op_busy === 1'b1) busy_cnt <= busy_cnt + 1;

  nvm_if link ();
  nvm_core_port u_nvm_core_port (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_sel(cmd_sel), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_indirect(cmd_indirect), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_route(rsp_route), .rsp_addr(rsp_addr), .bus(link));
  data_nvm_access_controller #(.LARGE(1'b1), .ERASE_CYCLES(20'(ERASE)),
    .PROG_CYCLES(20'(PROG))) u_data_nvm_access_controller (.clk(clk), .rst_n(rst_n),
    .bus(link), .irq(irq), .op_busy(op_busy));
  nvm_link_properties u_nvm_link_properties (.clk(clk), .rst_n(rst_n), .req(link.req),
    .kind(link.kind), .addr(link.addr), .indirect(link.indirect), .ack(link.ack),
    .rdata(link.rdata), .route(link.route), .rsp_addr(link.rsp_addr));

  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus_cmd(input nvm_pkg::req_kind_e k, input logic [2:0] s,
                         input logic [15:0] a, input logic [7:0] d, input logic i);
    int n;
    n = 0;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_sel <= s;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_indirect <= i;
    do begin
      @(posedge clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 50);
    cmd_valid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 100);
    if (n >= 100) bad_count++;
    got_d = {8'h00, rsp_data};
    got_r = 16'(rsp_route);
    got_a = rsp_addr;
  endtask

  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    bus_cmd(nvm_pkg::KIND_SFR_WR, s, 16'h0000, d, 1'b0);
  endtask

  task automatic rd(input logic [2:0] s, input logic [7:0] exp);
    bus_cmd(nvm_pkg::KIND_SFR_RD, s, 16'h0000, 8'h00, 1'b0);
    check(got_d, {8'h00, exp});
  endtask

  task automatic mv(input nvm_pkg::req_kind_e k, input logic [15:0] a, input logic i);
    bus_cmd(k, 3'h0, a, 8'h00, i);
  endtask

  task automatic idle_after(input int c);
    repeat (c) @(posedge clk);
    check({15'h0, op_busy}, 16'h0000);
  endtask

  task automatic wait_idle(input int lo);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (op_busy !== 1'b0 && n < 500);
    check(16'(busy_cnt - busy_base >= lo && busy_cnt - busy_base <= lo + 2), 16'h0001);
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_no_enable;
    wr(3'h5, 8'h20);
    mv(nvm_pkg::KIND_MOVE_RD, 16'h0010, 1'b0);
    check(got_r, R_EXT);
    wr(3'h1, 8'h07);
    wr(3'h2, 8'hF0);
    wr(3'h0, 8'h80);
    idle_after(3);
    rd(3'h0, 8'h00);
  endtask

  task automatic t_erase;
    busy_base = busy_cnt;
    wr(3'h0, 8'hA0);
    check({15'h0, op_busy}, 16'h0001);
    rd(3'h0, 8'hA0);
    wr(3'h1, 8'h00);
    wr(3'h3, 8'h5A);
    wr(3'h0, 8'h60);
    rd(3'h1, 8'h07);
    rd(3'h3, 8'h5A);
    wait_idle(ERASE);
    rd(3'h0, 8'h30);
    check({15'h0, irq}, 16'h0001);
    mv(nvm_pkg::KIND_MOVE_RD, 16'h07C0, 1'b0);
    check(got_d, 16'h00FF);
    check(got_r, R_ARR);
    wr(3'h4, 8'h07);
    mv(nvm_pkg::KIND_MOVE_RD, 16'h00FF, 1'b1);
    check(got_d, 16'h00FF);
    check(got_a, 16'h07FF);
    wr(3'h0, 8'h70);
    idle_after(3);
  endtask

  task automatic t_program;
    wr(3'h0, 8'h20);
    repeat (2) @(posedge clk);
    check({15'h0, irq}, 16'h0000);
    wr(3'h5, 8'h00);
    wr(3'h2, 8'hF0);
    busy_base = busy_cnt;
    wr(3'h0, 8'h60);
    wr(3'h3, 8'h00);
    wr(3'h0, 8'hA0);
    wr(3'h2, 8'h00);
    rd(3'h3, 8'h5A);
    wait_idle(PROG);
    rd(3'h0, 8'h30);
    check({15'h0, irq}, 16'h0000);
    mv(nvm_pkg::KIND_MOVE_RD, 16'h07F0, 1'b0);
    check(got_d, 16'h005A);
    mv(nvm_pkg::KIND_MOVE_RD, 16'h07F1, 1'b0);
    check(got_d, 16'h00FF);
  endtask

  task automatic t_range;
    wr(3'h0, 8'h20);
    wr(3'h1, 8'h10);
    wr(3'h2, 8'h00);
    wr(3'h0, 8'hA0);
    idle_after(3);
    wr(3'h0, 8'h60);
    idle_after(3);
    mv(nvm_pkg::KIND_MOVE_RD, 16'h2000, 1'b0);
    check(got_r, R_EXT);
    wr(3'h4, 8'h10);
    mv(nvm_pkg::KIND_MOVE_RD, 16'h0000, 1'b1);
    check(got_r, R_NONE);
    mv(nvm_pkg::KIND_MOVE_WR, 16'h07F0, 1'b0);
    check(got_r, R_NONE);
    mv(nvm_pkg::KIND_MOVE_WR, 16'h2000, 1'b0);
    check(got_r, R_EXT);
    mv(nvm_pkg::KIND_MOVE_WR, 16'h07F0, 1'b1);
    check(got_r, R_NONE);
    mv(nvm_pkg::KIND_MOVE_RD, 16'h07F0, 1'b0);
    check(got_d, 16'h005A);
  endtask

  // ------------------------------
  // Sequence and verdict
  // ------------------------------
  task automatic close_out;
    if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_no_enable();
    t_erase();
    t_program();
    t_range();
    close_out();
  end

  initial begin
    #(5 * 5000);
    bad_count++;
    close_out();
  end
endmodule
